//--- hdl/stream_pkg.sv
// stream_pkg: shared types and constants for the stream channel slave
// assumes a single clock domain shared with the upstream producer
package stream_pkg;

  // payload layout
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int USER_W = 4;
  localparam int ID_W = 4;
  localparam int DEST_W = 4;

  // reset values
  localparam logic READY_RST = 1'b0;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // one forward beat; every field travels from producer to consumer
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
    logic [USER_W-1:0] user;
    logic last;
    logic [ID_W-1:0] id;
    logic [DEST_W-1:0] dest;
  } beat_s;

  // slave acceptance modes
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_ARMED = 2'b01,
    ST_HOLD = 2'b11
  } slave_state_e;

endpackage : stream_pkg

//--- hdl/stream_slave.sv
// stream_slave: consumer end of one valid/ready stream channel
// assumes the producer shares clk and rstn and keeps the channel rules
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - a beat transfers only when valid and ready are high together
// - ready may rise before, with, or after valid
// - valid never depends on ready; ready may depend on valid
// - ready is never combinational from valid; it is registered
// - no combinational path from any channel input to any output
// - ready is pre-asserted whenever there is room outside the ST_RESET cycle, minimising latency
// - no combinational paths between related channels either
// - only ready runs backward; status leaves out of band
// - payload is taken only on an accepted beat
// - only valid is mandatory; other fields are optional
// - an omitted ready is taken as constant one
module stream_slave
  import stream_pkg::*;
#(
  parameter bit HAS_READY = 1'b1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stream channel from the producer
  input wire logic s_valid,
  input wire beat_s s_beat,
  output logic s_ready,
  // user side: captured beat
  output logic out_valid,
  output beat_s out_beat,
  input wire logic out_take,
  // out-of-band status
  output logic [15:0] beat_count
);

  slave_state_e state_r, state_nxt;
  logic ready_r, ready_nxt;
  logic hold_r, hold_nxt;
  beat_s beat_r, beat_nxt;
  logic [15:0] count_r, count_nxt;
  logic ready_eff;
  logic xfer;
  logic capture;

  // handshake qualifier, shared by the datapath and the checks below
  function automatic logic fire(input logic valid_in, input logic ready_in);
    return valid_in && ready_in;
  endfunction : fire

  // effective ready: constant one when the port is omitted
  assign ready_eff = HAS_READY ? ready_r : 1'b1;
  // a beat counts only when both sides agree in one cycle
  assign xfer = fire(s_valid, ready_eff);
  // the first cycle out of reset takes nothing, even with ready omitted; state_r is still ST_RESET there
  assign capture = xfer && (state_r == ST_ARMED);

  // control next state; with HAS_READY set a full slot always sees ready low, so no beat is overwritten
  always_comb
  begin
    state_nxt = state_r;
    ready_nxt = ready_r;
    hold_nxt = hold_r;
    case (state_r)
      ST_RESET:
      begin
        state_nxt = ST_ARMED;
        ready_nxt = 1'b1; // pre-assert before any valid
      end
      ST_ARMED:
      begin
        if (capture)
        begin
          hold_nxt = 1'b1;
          // registered drop costs a bubble per beat but never loses one
          if (HAS_READY)
          begin
            state_nxt = ST_HOLD;
            ready_nxt = 1'b0;
          end
        end
        else if (out_take)
        begin
          hold_nxt = 1'b0;
        end
      end
      ST_HOLD:
      begin
        if (out_take)
        begin
          hold_nxt = 1'b0;
          state_nxt = ST_ARMED;
          ready_nxt = 1'b1; // ready returns regardless of valid
        end
      end
      default:
      begin
        state_nxt = ST_RESET;
        ready_nxt = READY_RST;
      end
    endcase
  end

  // control registers; synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_r <= ST_RESET;
      ready_r <= READY_RST;
      hold_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      hold_r <= hold_nxt;
    end
  end

  // payload next state; without ready an untaken beat is simply overwritten
  always_comb
  begin
    beat_nxt = beat_r;
    count_nxt = count_r;
    if (capture)
    begin
      beat_nxt = s_beat;
      count_nxt = count_r + 16'h0001;
    end
  end

  // payload registers; synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      beat_r <= '0;
      count_r <= COUNT_RST;
    end
    else
    begin
      beat_r <= beat_nxt;
      count_r <= count_nxt;
    end
  end

  // all outputs straight from flip-flops
  assign s_ready = ready_r;
  assign out_valid = hold_r;
  assign out_beat = beat_r;
  assign beat_count = count_r;

  // helper: previous-cycle view of the channel
  logic prev_valid_r, prev_ready_r;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      prev_valid_r <= 1'b0;
      prev_ready_r <= 1'b0;
    end
    else
    begin
      prev_valid_r <= s_valid;
      prev_ready_r <= ready_eff;
    end
  end

  sequence beat_seq;
    fire(s_valid, ready_eff);
  endsequence

  sequence held_capture_seq;
    HAS_READY && fire(s_valid, s_ready);
  endsequence

  sequence stall_seq;
    HAS_READY && out_valid && !out_take;
  endsequence

  sequence take_seq;
    out_valid && out_take && !fire(s_valid, ready_eff);
  endsequence

  sequence armed_seq;
    HAS_READY && state_r == ST_ARMED;
  endsequence

  a_count_on_beat: assert property (@(posedge clk) disable iff (!rstn)
    beat_seq |=> beat_count == $past(beat_count) + 16'h0001)
    else $error("count did not follow an accepted beat");

  a_count_no_beat: assert property (@(posedge clk) disable iff (!rstn)
    !(s_valid && ready_eff) |=> $stable(beat_count))
    else $error("count moved without a beat");

  a_data_capture: assert property (@(posedge clk) disable iff (!rstn)
    beat_seq |=> out_beat == $past(s_beat) && out_valid)
    else $error("accepted beat not captured");

  a_ready_early: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_RESET |=> s_ready || !HAS_READY)
    else $error("ready not pre-asserted after reset");

  a_ready_reg: assert property (@(posedge clk) disable iff (!rstn)
    (s_valid && !prev_valid_r && !s_ready) |-> ##1 $stable(state_r) || state_r == ST_ARMED)
    else $error("ready path reacted to valid directly");

  a_hold_stall: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_HOLD && !out_take) |=> !s_ready && out_valid)
    else $error("ready rose while a beat was held");

  a_release_ready: assert property (@(posedge clk) disable iff (!rstn)
    (state_r == ST_HOLD && out_take) |=> s_ready ##0 !out_valid)
    else $error("ready did not return after release");

  a_no_ready_one: assert property (@(posedge clk) disable iff (!rstn)
    (!HAS_READY && s_valid) |=> out_valid)
    else $error("beat lost with ready omitted");

  a_reset_quiet: assert property (@(posedge clk)
    !rstn |=> !s_ready && !out_valid && beat_count == COUNT_RST)
    else $error("outputs not quiet after reset");

  // a captured beat closes the door in the very next cycle
  a_ready_drop: assert property (@(posedge clk) disable iff (!rstn)
    held_capture_seq |=> !s_ready && out_valid)
    else $error("ready stayed high after a capture");

  // with ready present, a waiting beat keeps its payload until taken
  a_stall_keep: assert property (@(posedge clk) disable iff (!rstn)
    stall_seq |=> out_valid && $stable(out_beat))
    else $error("held beat changed before it was taken");

  // a take with no new beat empties the slot
  a_take_clear: assert property (@(posedge clk) disable iff (!rstn)
    take_seq |=> !out_valid)
    else $error("slot not emptied by a take");

  // waiting for data means ready is already up
  a_armed_ready: assert property (@(posedge clk) disable iff (!rstn)
    armed_seq |-> s_ready)
    else $error("ready low while armed");

  // the armed state never holds a beat when ready exists
  a_armed_empty: assert property (@(posedge clk) disable iff (!rstn)
    armed_seq |-> !out_valid)
    else $error("armed with a beat still held");

  // with ready present, a full slot always shows ready low
  a_hold_low: assert property (@(posedge clk) disable iff (!rstn)
    (HAS_READY && state_r == ST_HOLD) |-> !s_ready)
    else $error("ready high while holding");

  // with ready present, no beat can land on top of a held one
  a_full_blocks: assert property (@(posedge clk) disable iff (!rstn)
    (HAS_READY && out_valid) |-> !s_ready)
    else $error("ready high with a full slot");

  // the reset state lasts exactly one cycle
  a_reset_exit: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_RESET |=> state_r == ST_ARMED)
    else $error("reset state not left");

  // the hold state always has a beat to show
  a_hold_flag: assert property (@(posedge clk) disable iff (!rstn)
    state_r == ST_HOLD |-> out_valid)
    else $error("hold state without a beat");

  // payload moves only on an accepted beat
  a_beat_only: assert property (@(posedge clk) disable iff (!rstn)
    !fire(s_valid, ready_eff) |=> $stable(out_beat))
    else $error("payload moved without a beat");

  // with ready omitted every beat offered in the armed state counts
  a_no_ready_count: assert property (@(posedge clk) disable iff (!rstn)
    (!HAS_READY && s_valid && state_r == ST_ARMED) |=> beat_count == $past(beat_count) + 16'h0001)
    else $error("offered beat not counted with ready omitted");

  // ready stays up while the producer is idle
  a_ready_stays: assert property (@(posedge clk) disable iff (!rstn)
    (HAS_READY && s_ready && !s_valid) |=> s_ready)
    else $error("ready fell while idle");

  // ready rises only when the slot is empty
  a_ready_rise: assert property (@(posedge clk) disable iff (!rstn)
    $rose(s_ready) |-> !out_valid)
    else $error("ready rose with a full slot");

  // the count moves only on a capture
  a_count_cause: assert property (@(posedge clk) disable iff (!rstn)
    $changed(beat_count) |-> $past(capture))
    else $error("count moved without a capture");

  // a beat appears only after one was offered
  a_out_cause: assert property (@(posedge clk) disable iff (!rstn)
    (out_valid && !$past(out_valid)) |-> $past(s_valid))
    else $error("beat appeared with nothing offered");

endmodule : stream_slave

`default_nettype wire

//--- tb/stream_src.sv
// stream_src: producer model feeding the slave channel
// assumes shared clk and rstn; the bench pushes beats into q
`timescale 1ns/1ps
`default_nettype none
module stream_src
  import stream_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // channel and pacing
  input wire logic s_ready,
  input wire logic slow,
  output logic s_valid,
  output beat_s s_beat
);
  beat_s q[$];
  initial s_valid = 1'b0;
  initial s_beat = '0;
  // offer only when idle or just accepted; an idle bus inverts its bits every cycle, so it shows stale data every other cycle
  always @(posedge clk)
  begin
    if (!rstn)
      s_valid <= 1'b0;
    else if (!s_valid || s_ready)
    begin
      s_valid <= q.size() != 0 && !slow;
      s_beat <= (q.size() != 0 && !slow) ? q.pop_front() : ~s_beat;
    end
  end
endmodule : stream_src
`default_nettype wire

//--- tb/tb.sv
// tb: drives the slave through stream_src, checks captured beats against a queue
// assumes one 250 MHz clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tb
  import stream_pkg::*;
;
  localparam int BW = $bits(beat_s);
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic out_take = 1'b0;
  logic s_valid, s_ready, out_valid;
  beat_s s_beat, out_beat;
  logic [15:0] beat_count;
  beat_s exp[$];
  beat_s last_b;
  logic nr_ready, nr_valid;
  beat_s nr_beat;
  logic [15:0] nr_count;
  int nv = 0;
  int seed = 32'hda3a;
  int err_total = 0;
  int checked = 0;
  int n;
  always #2 clk = ~clk;
  stream_src src (.clk(clk), .rstn(rstn), .s_ready(s_ready), .slow(slow), .s_valid(s_valid), .s_beat(s_beat));
  stream_slave DUT (.clk(clk), .rstn(rstn), .s_valid(s_valid), .s_beat(s_beat), .s_ready(s_ready),
    .out_valid(out_valid), .out_beat(out_beat), .out_take(out_take), .beat_count(beat_count));
  // second slave with ready omitted, watching the same channel
  stream_slave #(.HAS_READY(1'b0)) DUT_nr (.clk(clk), .rstn(rstn), .s_valid(s_valid), .s_beat(s_beat),
    .s_ready(nr_ready), .out_valid(nr_valid), .out_beat(nr_beat), .out_take(1'b1), .beat_count(nr_count));
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // queue the beat for both the producer and the scoreboard
  task automatic send();
    beat_s b;
    b = BW'({$random(seed), $random(seed)});
    exp.push_back(b);
    last_b = b;
    src.q.push_back(b);
  endtask : send
  // every taken beat must match the oldest queued one, in order
  always @(posedge clk)
  begin
    if (rstn && s_valid === 1'b1)
      nv++;
    if (rstn && out_valid === 1'b1 && out_take === 1'b1)
    begin
      if (exp.size() == 0)
        chk("extra_beat", 64'(1), 64'(0));
      else
        chk("out_beat", 64'(out_beat), 64'(exp.pop_front()));
    end
  end
  initial
  begin
    repeat (15) @(posedge clk);
    chk("rst_ready", 64'(s_ready), 64'(READY_RST));
    chk("rst_count", 64'(beat_count), 64'(COUNT_RST));
    @(posedge clk) rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pre_ready", 64'(s_ready), 64'(1));
    $display("test reset done");
    repeat (3) send();
    repeat (8) @(posedge clk);
    chk("stall_ready", 64'(s_ready), 64'(0));
    chk("stall_valid", 64'(s_valid), 64'(1));
    chk("stall_out", 64'(out_valid), 64'(1));
    $display("test stall done");
    repeat (40) send();
    n = 0;
    while ((exp.size() != 0 || out_valid !== 1'b0) && n < 2000)
    begin
      @(posedge clk);
      out_take <= $random(seed) % 3 != 0;
      slow <= $random(seed) % 4 == 0;
      n++;
    end
    if (n == 2000)
      chk("timeout", 64'(1), 64'(0));
    chk("beat_count", 64'(beat_count), 64'(43));
    chk("nr_count", 64'(nr_count), 64'(nv));
    chk("nr_beat", 64'(nr_beat), 64'(last_b));
    chk("nr_valid", 64'(nr_valid), 64'(0));
    chk("nr_ready", 64'(nr_ready), 64'(1));
    $display("test random done");
    test_done();
  end
endmodule : tb
`default_nettype wire
